// [xrx_pkg.sv]
// Shared constants and carrier types for the receive alignment block
package xrx_pkg;

   // ======================================================
   // Link geometry
   localparam int NUM_LANES = 4;

   // ======================================================
   // Control code groups (decoded 8-bit values with K flag)
   localparam logic [7:0] CODE_COMMA = 8'hBC;
   localparam logic [7:0] CODE_ALIGN = 8'h7C;
   localparam logic [7:0] CODE_RATE = 8'h1C;

   // ======================================================
   // Lane synchronisation counts
   localparam logic [2:0] SYNC_COMMAS = 3'h4;
   localparam logic [2:0] SYNC_BAD_LIMIT = 3'h4;
   localparam logic [2:0] SYNC_GOOD_RUN = 3'h4;

   // ======================================================
   // Deskew
   localparam int DSK_DEPTH = 16;
   localparam logic [3:0] DSK_WINDOW = 4'hA;
   localparam logic [2:0] DSK_ALIGN_NEED = 3'h4;
   localparam logic [2:0] DSK_MISALIGN_LIMIT = 3'h4;

   // ======================================================
   // Rate match
   localparam int RM_PPM_TOTAL = 200;
   localparam int RM_DEPTH = 8;
   localparam logic [3:0] RM_LOW = 4'h3;
   localparam logic [3:0] RM_MID = 4'h4;
   localparam logic [3:0] RM_HIGH = 4'h6;
   localparam logic [3:0] RM_FULL = 4'h8;
   localparam logic [1:0] RM_FLAG_HOLD = 2'h2;

   // ======================================================
   // Carriers
   typedef struct packed {
      logic err;
      logic k;
      logic [7:0] data;
   } xrx_cg_t;

   typedef struct packed {
      xrx_cg_t [NUM_LANES-1:0] lane;
   } xrx_col_t;

   typedef enum logic {SYNC_LOSS, SYNC_OK} xrx_sync_state_t;
   typedef enum logic [1:0] {DSK_HOLD, DSK_WAIT, DSK_RUN} xrx_dsk_state_t;

endpackage

// [xrx_lane_sync.sv]
// Per-lane code-group synchronisation machine
module xrx_lane_sync (
   // Clock and reset
   input wire logic clk,
   input wire logic rstn,
   // Decoded code group
   input wire xrx_pkg::xrx_cg_t cg,
   // Status
   output logic sync_ok
);

   xrx_pkg::xrx_sync_state_t state;
   logic [2:0] comma_cnt;
   logic [2:0] bad_cnt;
   logic [2:0] good_cnt;
   logic is_comma;

   assign is_comma = cg.k && (cg.data == xrx_pkg::CODE_COMMA) && !cg.err;

   // ======================================================
   // Acquire and lose
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state <= xrx_pkg::SYNC_LOSS;
         comma_cnt <= 3'h0;
         bad_cnt <= 3'h0;
         good_cnt <= 3'h0;
      end else begin
         case (state)
            xrx_pkg::SYNC_LOSS: begin
               bad_cnt <= 3'h0;
               good_cnt <= 3'h0;
               if (cg.err) begin
                  comma_cnt <= 3'h0; // RULE1
               end else if (is_comma) begin
                  if (comma_cnt == xrx_pkg::SYNC_COMMAS - 3'h1) begin
                     state <= xrx_pkg::SYNC_OK; // RULE1
                     comma_cnt <= 3'h0;
                  end else begin
                     comma_cnt <= comma_cnt + 3'h1;
                  end
               end
            end
            default: begin
               if (cg.err) begin
                  good_cnt <= 3'h0;
                  if (bad_cnt == xrx_pkg::SYNC_BAD_LIMIT - 3'h1) begin
                     state <= xrx_pkg::SYNC_LOSS; // RULE3
                     bad_cnt <= 3'h0;
                  end else begin
                     bad_cnt <= bad_cnt + 3'h1;
                  end
               end else if (good_cnt == xrx_pkg::SYNC_GOOD_RUN - 3'h1) begin
                  // A full run of valid groups forgives earlier errors
                  good_cnt <= 3'h0;
                  bad_cnt <= 3'h0; // RULE3
               end else begin
                  good_cnt <= good_cnt + 3'h1;
               end
            end
         endcase
      end
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         sync_ok <= 1'b0;
      end else begin
         sync_ok <= (state == xrx_pkg::SYNC_OK); // RULE2
      end
   end

endmodule

// [xrx_rx_align.sv]
// Four-lane receive sync, deskew and rate match
// How it works
// RULE1: Four commas without error give lane sync
// RULE2: Lane sync output high while synchronized
// RULE3: Four errors without four valids lose sync
// RULE4: Far end sends align groups on all lanes
// RULE5: Deskew waits for sync on all lanes
// RULE6: Pointers hold until first align group
// RULE7: After align, write advances, read frozen
// RULE8: All aligns within ten cycles release reads
// RULE9: Three more aligned columns assert deskewed
// RULE10: Four misaligned columns drop deskewed
// RULE11: Rate match absorbs 200 PPM total offset
// RULE12: Far end sends rate columns on all lanes
// RULE13: Rate match needs sync and deskew
// RULE14: Insert or delete whole rate columns
// RULE15: One-cycle drop pulse per deleted column
// RULE16: One-cycle add pulse per inserted column
// RULE17: Full or empty flagged three cycles, no recovery
// RULE18: Fabric resets receiver after full or empty
// RULE19: Sync loss returns deskew to hold
module xrx_rx_align (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // Decoded code groups, one per lane
   input wire xrx_pkg::xrx_col_t RX_CG,
   // Status
   output logic [3:0] LANE_SYNC_OK,
   output logic LANES_DESKEWED,
   // Aligned, rate-matched data
   output xrx_pkg::xrx_col_t RX_COLUMN,
   output logic RX_VALID,
   // Rate-match events
   output logic [3:0] COLUMN_DROPPED_PULSE,
   output logic [3:0] COLUMN_ADDED_PULSE,
   output logic RM_FULL_FLAG,
   output logic RM_EMPTY_FLAG
);

   // ======================================================
   // Lane synchronisation
   for (genvar g = 0; g < xrx_pkg::NUM_LANES; g++) begin : g_lane
      xrx_lane_sync u_sync (
         .clk(CLOCK),
         .rstn(RSTN),
         .cg(RX_CG.lane[g]),
         .sync_ok(LANE_SYNC_OK[g])
      );
   end
   logic all_sync;
   assign all_sync = &LANE_SYNC_OK;
   // ======================================================
   // Deskew
   xrx_pkg::xrx_dsk_state_t dsk_state;
   xrx_pkg::xrx_cg_t dsk_mem [xrx_pkg::NUM_LANES][xrx_pkg::DSK_DEPTH];
   logic [3:0] wr_ptr [xrx_pkg::NUM_LANES];
   logic [3:0] rd_ptr;
   logic [3:0] seen;
   logic [3:0] is_a;
   logic [3:0] wr_en;
   logic [3:0] win_cnt;
   xrx_pkg::xrx_col_t dsk_out;
   logic dsk_vld;
   logic [2:0] align_cnt;
   logic [2:0] mis_cnt;
   logic col_aligned;
   logic col_misaligned;
   logic drop_align;
   always_comb begin
      for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
         is_a[i] = RX_CG.lane[i].k && (RX_CG.lane[i].data == xrx_pkg::CODE_ALIGN);
      end
   end
   // Write only once a lane has seen its align group
   always_comb begin
      case (dsk_state)
         xrx_pkg::DSK_RUN: wr_en = 4'hF; // RULE7
         xrx_pkg::DSK_WAIT: wr_en = seen | is_a; // RULE7
         default: wr_en = all_sync ? is_a : 4'h0; // RULE5 RULE6
      endcase
   end
   always_ff @(posedge CLOCK) begin
      for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
         if (wr_en[i]) begin
            dsk_mem[i][wr_ptr[i]] <= RX_CG.lane[i];
         end
      end
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         dsk_state <= xrx_pkg::DSK_HOLD;
         seen <= 4'h0;
         win_cnt <= 4'h0;
         rd_ptr <= 4'h0;
         for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
            wr_ptr[i] <= 4'h0;
         end
      end else if (!all_sync || drop_align) begin
         dsk_state <= xrx_pkg::DSK_HOLD; // RULE19 RULE10
         seen <= 4'h0;
         win_cnt <= 4'h0;
         rd_ptr <= 4'h0;
         for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
            wr_ptr[i] <= 4'h0;
         end
      end else begin
         for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
            if (wr_en[i]) begin
               wr_ptr[i] <= wr_ptr[i] + 4'h1;
            end
         end
         case (dsk_state)
            xrx_pkg::DSK_HOLD: begin
               if (is_a == 4'hF) begin
                  dsk_state <= xrx_pkg::DSK_RUN; // RULE8
               end else if (is_a != 4'h0) begin
                  dsk_state <= xrx_pkg::DSK_WAIT;
                  seen <= is_a;
                  win_cnt <= 4'h1;
               end
            end
            xrx_pkg::DSK_WAIT: begin
               seen <= seen | is_a;
               win_cnt <= win_cnt + 4'h1;
               if ((seen | is_a) == 4'hF) begin
                  dsk_state <= xrx_pkg::DSK_RUN; // RULE8
               end else if (win_cnt == xrx_pkg::DSK_WINDOW - 4'h1) begin
                  // Skew too large: start over from the hold state
                  dsk_state <= xrx_pkg::DSK_HOLD; // RULE8
                  seen <= 4'h0;
                  win_cnt <= 4'h0;
                  for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
                     wr_ptr[i] <= 4'h0;
                  end
               end
            end
            default: begin
               rd_ptr <= rd_ptr + 4'h1; // RULE8
            end
         endcase
      end
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         dsk_out <= '0;
         dsk_vld <= 1'b0;
      end else begin
         dsk_vld <= all_sync && !drop_align && (dsk_state == xrx_pkg::DSK_RUN);
         for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
            dsk_out.lane[i] <= dsk_mem[i][rd_ptr];
         end
      end
   end
   always_comb begin
      col_aligned = dsk_vld;
      col_misaligned = 1'b0;
      for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
         if (!(dsk_out.lane[i].k && dsk_out.lane[i].data == xrx_pkg::CODE_ALIGN)) begin
            col_aligned = 1'b0;
         end else begin
            col_misaligned = dsk_vld;
         end
      end
      if (col_aligned) begin
         col_misaligned = 1'b0;
      end
   end
   assign drop_align = LANES_DESKEWED && col_misaligned && (mis_cnt == xrx_pkg::DSK_MISALIGN_LIMIT - 3'h1);
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         LANES_DESKEWED <= 1'b0;
         align_cnt <= 3'h0;
         mis_cnt <= 3'h0;
      end else if (!all_sync || !dsk_vld || drop_align) begin
         LANES_DESKEWED <= 1'b0; // RULE10 RULE19
         align_cnt <= 3'h0;
         mis_cnt <= 3'h0;
      end else if (!LANES_DESKEWED) begin
         if (col_aligned) begin
            if (align_cnt == xrx_pkg::DSK_ALIGN_NEED - 3'h1) begin
               LANES_DESKEWED <= 1'b1; // RULE9
            end
            align_cnt <= align_cnt + 3'h1;
         end else if (col_misaligned) begin
            align_cnt <= 3'h0;
         end
      end else if (col_aligned) begin
         mis_cnt <= 3'h0; // RULE10
      end else if (col_misaligned) begin
         mis_cnt <= mis_cnt + 3'h1; // RULE10
      end
   end
   // ======================================================
   // Rate match: thresholds sized for 200 PPM drift between R columns
   xrx_pkg::xrx_col_t rm_mem [xrx_pkg::RM_DEPTH];
   logic [2:0] rm_wp;
   logic [2:0] rm_rp;
   logic [3:0] rm_cnt;
   logic rm_run;
   logic rm_started;
   logic in_r;
   logic out_r;
   logic rm_del;
   logic rm_ins;
   logic rm_wr;
   logic rm_rd;
   logic full_ev;
   logic empty_ev;
   logic [1:0] full_hold;
   logic [1:0] empty_hold;
   assign rm_run = all_sync && LANES_DESKEWED && dsk_vld; // RULE13
   always_comb begin
      in_r = 1'b1;
      out_r = 1'b1;
      for (int i = 0; i < xrx_pkg::NUM_LANES; i++) begin
         if (!(dsk_out.lane[i].k && dsk_out.lane[i].data == xrx_pkg::CODE_RATE)) begin
            in_r = 1'b0;
         end
         if (!(RX_COLUMN.lane[i].k && RX_COLUMN.lane[i].data == xrx_pkg::CODE_RATE)) begin
            out_r = 1'b0;
         end
      end
   end
   assign rm_del = rm_run && in_r && (rm_cnt >= xrx_pkg::RM_HIGH); // RULE14 RULE11
   assign rm_ins = rm_started && RX_VALID && out_r && (rm_cnt < xrx_pkg::RM_LOW); // RULE14
   assign full_ev = rm_run && !rm_del && (rm_cnt == xrx_pkg::RM_FULL);
   assign empty_ev = rm_started && !rm_ins && (rm_cnt == 4'h0);
   // Full and empty are only reported; the fabric must reset to recover
   assign rm_wr = rm_run && !rm_del && !full_ev; // RULE17
   assign rm_rd = rm_started && !rm_ins && !empty_ev; // RULE17
   always_ff @(posedge CLOCK) begin
      if (rm_wr) begin
         rm_mem[rm_wp] <= dsk_out;
      end
   end
   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         rm_wp <= 3'h0;
         rm_rp <= 3'h0;
         rm_cnt <= 4'h0;
         rm_started <= 1'b0;
         RX_COLUMN <= '0;
         RX_VALID <= 1'b0;
      end else if (!rm_run) begin
         rm_wp <= 3'h0; // RULE13
         rm_rp <= 3'h0;
         rm_cnt <= 4'h0;
         rm_started <= 1'b0;
         RX_VALID <= 1'b0;
      end else begin
         if (rm_wr) begin
            rm_wp <= rm_wp + 3'h1;
         end
         if (rm_rd) begin
            rm_rp <= rm_rp + 3'h1;
            RX_COLUMN <= rm_mem[rm_rp];
         end
         rm_cnt <= rm_cnt + {3'h0, rm_wr} - {3'h0, rm_rd};
         if (rm_cnt >= xrx_pkg::RM_MID) begin
            rm_started <= 1'b1;
         end
         // An inserted column repeats the R column already on the output
         RX_VALID <= rm_rd || rm_ins; // RULE16
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         COLUMN_DROPPED_PULSE <= 4'h0;
         COLUMN_ADDED_PULSE <= 4'h0;
      end else begin
         COLUMN_DROPPED_PULSE <= {4{rm_del}}; // RULE15
         COLUMN_ADDED_PULSE <= {4{rm_ins && rm_run}}; // RULE16
      end
   end

   always_ff @(posedge CLOCK or negedge RSTN) begin
      if (!RSTN) begin
         RM_FULL_FLAG <= 1'b0;
         RM_EMPTY_FLAG <= 1'b0;
         full_hold <= 2'h0;
         empty_hold <= 2'h0;
      end else begin
         RM_FULL_FLAG <= full_ev || (full_hold != 2'h0); // RULE17
         RM_EMPTY_FLAG <= empty_ev || (empty_hold != 2'h0); // RULE17
         if (full_ev) begin
            full_hold <= xrx_pkg::RM_FLAG_HOLD;
         end else if (full_hold != 2'h0) begin
            full_hold <= full_hold - 2'h1;
         end
         if (empty_ev) begin
            empty_hold <= xrx_pkg::RM_FLAG_HOLD;
         end else if (empty_hold != 2'h0) begin
            empty_hold <= empty_hold - 2'h1;
         end
      end
   end

endmodule

// [xrx_rx_align_checker.sv]
// Port assertions for the receive alignment block
module xrx_rx_align_checker (
   // Clock and reset
   input wire logic CLOCK,
   input wire logic RSTN,
   // Link and status
   input wire xrx_pkg::xrx_col_t RX_CG,
   input wire logic [3:0] LANE_SYNC_OK,
   input wire logic LANES_DESKEWED,
   // Rate-match events
   input wire logic [3:0] COLUMN_DROPPED_PULSE,
   input wire logic [3:0] COLUMN_ADDED_PULSE,
   input wire logic RM_FULL_FLAG,
   input wire logic RM_EMPTY_FLAG
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking @(posedge CLOCK);
   endclocking
   default disable iff (!RSTN);
   // ==========
   // Lane 0 stands for all lanes; status lags the taken group by two edges
   logic comma0;
   assign comma0 = RX_CG.lane[0].k && RX_CG.lane[0].data == xrx_pkg::CODE_COMMA && !RX_CG.lane[0].err;
   a_sync_on_comma: assert property ($rose(LANE_SYNC_OK[0]) |-> $past(comma0, 2))
      else $error("lane sync rose without a comma");
   a_loss_on_error: assert property ($fell(LANE_SYNC_OK[0]) |-> $past(RX_CG.lane[0].err, 2))
      else $error("lane sync fell without an error");
   a_deskew_needs_sync: assert property ($rose(LANES_DESKEWED) |-> &LANE_SYNC_OK)
      else $error("deskew rose without lane sync");
   a_deskew_sync_loss: assert property (LANES_DESKEWED && !(&LANE_SYNC_OK) |=> !LANES_DESKEWED)
      else $error("deskew kept after sync loss");
   a_drop_all_lanes: assert property (COLUMN_DROPPED_PULSE != 4'h0 |->
      COLUMN_DROPPED_PULSE == 4'hF && ($past(LANES_DESKEWED) || $past(LANES_DESKEWED, 2)))
      else $error("drop pulse not on all lanes or not deskewed");
   a_add_all_lanes: assert property (COLUMN_ADDED_PULSE != 4'h0 |-> COLUMN_ADDED_PULSE == 4'hF)
      else $error("add pulse not on all lanes");
   a_full_held: assert property ($rose(RM_FULL_FLAG) |=> RM_FULL_FLAG [*2])
      else $error("full flag shorter than three cycles");
   a_empty_held: assert property ($rose(RM_EMPTY_FLAG) |=> RM_EMPTY_FLAG [*2])
      else $error("empty flag shorter than three cycles");
endmodule

bind xrx_rx_align xrx_rx_align_checker xrx_rx_align_checker_i (.CLOCK(CLOCK), .RSTN(RSTN), .RX_CG(RX_CG),
   .LANE_SYNC_OK(LANE_SYNC_OK), .LANES_DESKEWED(LANES_DESKEWED), .COLUMN_DROPPED_PULSE(COLUMN_DROPPED_PULSE),
   .COLUMN_ADDED_PULSE(COLUMN_ADDED_PULSE), .RM_FULL_FLAG(RM_FULL_FLAG), .RM_EMPTY_FLAG(RM_EMPTY_FLAG));

// [xrx_far_tx.sv]
// Behavioural far-end transmitter with per-lane skew
module xrx_far_tx (
   // Clock
   input wire logic clk,
   // Column kind, error lanes, per-lane delay
   input wire logic [1:0] kind,
   input wire logic [3:0] bad,
   input wire logic [7:0] skew,
   // Lanes as seen at the receiver
   output xrx_pkg::xrx_col_t col
);
   timeunit 1ns;
   timeprecision 1ns;
   xrx_pkg::xrx_col_t dly [4] = '{default: '0};
   logic [7:0] seq = 8'h00;
   // Control groups leave on all lanes together; skew is the medium's
   always @(negedge clk) begin
      seq <= seq + 8'h01;
      for (int i = 0; i < 4; i++) begin
         dly[0].lane[i].err <= bad[i];
         dly[0].lane[i].k <= kind != 2'h0;
         case (kind)
            2'h1: dly[0].lane[i].data <= xrx_pkg::CODE_COMMA;
            2'h2: dly[0].lane[i].data <= xrx_pkg::CODE_ALIGN;
            2'h3: dly[0].lane[i].data <= xrx_pkg::CODE_RATE;
            default: dly[0].lane[i].data <= seq;
         endcase
      end
      for (int j = 1; j < 4; j++) begin
         dly[j] <= dly[j-1];
      end
   end
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         col.lane[i] = dly[skew[2*i +: 2]].lane[i];
      end
   end
endmodule

// [tb.sv]
// Self-checking bench for the receive alignment block
module tb;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock;
   logic rstn;
   logic [1:0] kind;
   logic [3:0] bad;
   logic [7:0] skew;
   xrx_pkg::xrx_col_t cg;
   xrx_pkg::xrx_col_t col;
   logic [3:0] sync_ok;
   logic [3:0] dropped;
   logic [3:0] added;
   logic deskewed;
   logic valid;
   logic full;
   logic empty;
   int mismatches = 0;
   int n_checks = 0;

   xrx_far_tx xrx_far_tx_i (.clk(clock), .kind(kind), .bad(bad), .skew(skew), .col(cg));
   xrx_rx_align xrx_rx_align_i (.CLOCK(clock), .RSTN(rstn), .RX_CG(cg), .LANE_SYNC_OK(sync_ok),
      .LANES_DESKEWED(deskewed), .RX_COLUMN(col), .RX_VALID(valid), .COLUMN_DROPPED_PULSE(dropped),
      .COLUMN_ADDED_PULSE(added), .RM_FULL_FLAG(full), .RM_EMPTY_FLAG(empty));

   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end

   // ==========
   // Shared tasks
   task automatic end_of_test;
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("wrong value %s expected %h seen %h", what, exp, got);
      end
   endtask

   // Inputs change at the falling edge only
   task automatic send(input logic [1:0] k, input logic [3:0] b, input int n);
      repeat (n) begin
         kind <= k;
         bad <= b;
         @(negedge clock);
      end
   endtask

   function automatic logic seen(input int id);
      case (id)
         0: return sync_ok === 4'hF;
         1: return deskewed === 1'b1;
         2: return deskewed === 1'b0;
         default: return valid === 1'b1 && col.lane[0] === {2'b01, xrx_pkg::CODE_RATE};
      endcase
   endfunction

   task automatic await(input string what, input int id, input int lim);
      for (int i = 0; i < lim && !seen(id); i++) @(negedge clock);
      n_checks++;
      if (!seen(id)) begin
         mismatches++;
         $display("wrong value %s expected 1 seen 0", what);
         end_of_test();
      end
   endtask

   // Align column then seven idle words, well inside the skew window
   task automatic a_cols(input int n);
      repeat (n) begin
         send(2'h2, 4'h0, 1);
         send(2'h0, 4'h0, 7);
      end
   endtask

   // ==========
   // Scenarios
   task automatic t_sync;
      send(2'h1, 4'h0, 3);
      send(2'h0, 4'h0, 6);
      check("sync after three commas", 40'h0, {36'h0, sync_ok});
      send(2'h1, 4'h0, 1);
      await("sync after fourth comma", 0, 8);
   endtask

   task automatic t_loss;
      repeat (4) begin
         send(2'h0, 4'h4, 1);
         send(2'h0, 4'h0, 4);
      end
      check("sync with spaced errors", 40'hF, {36'h0, sync_ok});
      send(2'h0, 4'h4, 4);
      send(2'h0, 4'h0, 4);
      check("sync after error burst", 40'hB, {36'h0, sync_ok});
   endtask

   task automatic t_deskew;
      skew <= 8'hC4;
      a_cols(4);
      check("deskew with lane unsynced", 40'h0, {39'h0, deskewed});
      send(2'h1, 4'h0, 4);
      await("lane resync", 0, 8);
      a_cols(3);
      check("deskew and valid early", 40'h0, {38'h0, deskewed, valid});
      a_cols(1);
      await("deskew after four columns", 1, 20);
   endtask

   task automatic t_rate;
      send(2'h3, 4'h0, 1);
      send(2'h0, 4'h0, 1);
      await("rate column out", 3, 40);
      check("rate column", {4{2'b01, xrx_pkg::CODE_RATE}}, col);
      check("no rate events", 40'h0, {30'h0, dropped, added, full, empty});
   endtask

   task automatic t_realign;
      // Lane 0 is among the lost lanes so its loss assertion is exercised
      send(2'h0, 4'h3, 4);
      await("deskew drop on sync loss", 2, 8);
      send(2'h1, 4'h0, 4);
      await("lanes resync", 0, 8);
      a_cols(4);
      await("deskew regained", 1, 20);
   endtask

   // Lane 3 moved two words early: each align column gives two misaligned columns
   task automatic t_misalign;
      skew <= 8'h44;
      a_cols(1);
      check("deskew after two misaligned", 40'h1, {39'h0, deskewed});
      a_cols(1);
      await("deskew drop on misalign", 2, 12);
   endtask

   initial begin
      rstn = 1'b0;
      kind = 2'h0;
      bad = 4'h0;
      skew = 8'h00;
      repeat (8) @(negedge clock);
      check("outputs in reset", 40'h0, {24'h0, sync_ok, deskewed, valid, dropped, added, full, empty});
      rstn <= 1'b1;
      t_sync();
      t_loss();
      t_deskew();
      t_rate();
      t_realign();
      t_misalign();
      rstn <= 1'b0;
      send(2'h0, 4'h0, 1);
      check("outputs after reset", 40'h0, {24'h0, sync_ok, deskewed, valid, dropped, added, full, empty});
      end_of_test();
   end
endmodule
